// >>> core/dspcc_pkg.sv
package dspcc_pkg;

	// register map, byte addresses
	localparam logic [11:0] DSPCC_CORE_CONTROL_OFFS = 12'h000;

	// field positions inside core_control
	localparam int DSPCC_RSVD_MSB   = 15;
	localparam int DSPCC_RSVD_LSB   = 13;
	localparam int DSPCC_US_BIT     = 12;
	localparam int DSPCC_EXIT_BIT   = 11;
	localparam int DSPCC_DEPTH_MSB  = 10;
	localparam int DSPCC_DEPTH_LSB  = 8;
	localparam int DSPCC_ACC_A_CLAMP_EN_BIT   = 7;
	localparam int DSPCC_ACC_B_CLAMP_EN_BIT   = 6;
	localparam int DSPCC_SATW_BIT   = 5;
	localparam int DSPCC_WIDE_BIT   = 4;
	localparam int DSPCC_MSB_BIT    = 3;
	localparam int DSPCC_PSW_BIT    = 2;
	localparam int DSPCC_RND_BIT    = 1;
	localparam int DSPCC_INT_BIT    = 0;

	localparam logic [15:0] DSPCC_CORE_CONTROL_RST = 16'h0020;

	// datapath geometry
	localparam int DSPCC_ACC_W      = 40;
	localparam int DSPCC_NORM_W     = 32;
	localparam int DSPCC_OP_W       = 16;
	localparam int DSPCC_NUM_ACC    = 2;
	localparam int DSPCC_RND_LSB    = 16;
	localparam logic [15:0] DSPCC_RND_HALF = 16'h8000;

	typedef struct packed {
		logic [2:0] unused;
		logic       multiply_sign_select;
		logic       loop_early_exit;
		logic [2:0] loop_nest_depth;
		logic       acc_a_clamp_en;
		logic       acc_b_clamp_en;
		logic       write_clamp_en;
		logic       clamp_width_select;
		logic       priority_level_msb;
		logic       program_space_window;
		logic       rounding_select;
		logic       int_mode_select;
	} dspcc_ctrl_t;

endpackage

// >>> core/dspcc_clamp.sv
module dspcc_clamp
	import dspcc_pkg::*;
#(
	parameter int IN_W     = 41,
	parameter int OUT_W    = 40,
	parameter int NARROW_W = 32
) (
	// value and mode
	input  logic [IN_W-1:0]  value_i,
	input  logic             en_i,
	input  logic             wide_i,
	// result
	output logic [OUT_W-1:0] value_o
);

	localparam logic [OUT_W-1:0] MAX_NARROW = {{(OUT_W-NARROW_W+1){1'b0}}, {(NARROW_W-1){1'b1}}};
	localparam logic [OUT_W-1:0] MAX_WIDE   = {1'b0, {(OUT_W-1){1'b1}}};

	wire               neg        = value_i[IN_W-1];
	wire               fit_narrow = (&value_i[IN_W-1:NARROW_W-1]) | ~(|value_i[IN_W-1:NARROW_W-1]);
	wire               fit_wide   = (&value_i[IN_W-1:OUT_W-1]) | ~(|value_i[IN_W-1:OUT_W-1]);
	wire               overflow   = wide_i ? ~fit_wide : ~fit_narrow;
	wire [OUT_W-1:0]   max_val    = wide_i ? MAX_WIDE : MAX_NARROW;
	wire [OUT_W-1:0]   lim_val    = neg ? ~max_val : max_val;

	// without the enable the value simply wraps
	assign value_o = (en_i && overflow) ? lim_val : value_i[OUT_W-1:0];

endmodule

// >>> core/dspcc_core_control.sv
// Our own choices: the placing of the registers and register access over APB.
module dspcc_core_control
	import dspcc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  logic                   clk_sys_i,
	input  logic                   rstn_i,
	// apb slave
	input  logic                   psel_i,
	input  logic                   penable_i,
	input  logic                   pwrite_i,
	input  logic [ADDR_W-1:0]      paddr_i,
	input  logic [31:0]            pwdata_i,
	input  logic [3:0]             pstrb_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// loop hardware
	input  logic [2:0]             loop_nest_depth_i,
	input  logic                   loop_iter_end_i,
	output logic                   loop_terminate_o,
	// interrupt priority
	input  logic [2:0]             priority_level_low_i,
	input  logic                   priority_raise_i,
	input  logic                   priority_drop_i,
	output logic [3:0]             priority_level_o,
	// mode levels
	output logic                   program_space_window_o,
	output logic                   write_clamp_en_o,
	// multiplier
	input  logic [DSPCC_OP_W-1:0]  mul_x_i,
	input  logic [DSPCC_OP_W-1:0]  mul_y_i,
	output logic [31:0]            mul_product_o,
	// accumulators, raw sums one bit wider
	input  logic [DSPCC_ACC_W:0]   acc_a_i,
	input  logic [DSPCC_ACC_W:0]   acc_b_i,
	output logic [DSPCC_ACC_W-1:0] acc_a_o,
	output logic [DSPCC_ACC_W-1:0] acc_b_o,
	// data space write
	input  logic                   wr_acc_sel_i,
	output logic [DSPCC_OP_W-1:0]  wr_word_o
);

	dspcc_ctrl_t              ctrl_reg;
	dspcc_ctrl_t              ctrl_next;
	logic                     exit_pend_reg;
	logic                     exit_pend_next;
	logic                     term_reg;
	logic [3:0]               prio_reg;
	logic [31:0]              prdata_reg;
	logic                     pready_reg;
	logic                     pslverr_reg;
	logic [31:0]              product_reg;
	logic [DSPCC_ACC_W-1:0]   acc_reg [DSPCC_NUM_ACC];
	logic [DSPCC_OP_W-1:0]    wr_word_reg;

	// ---------------- apb decode
	wire        addr_hit  = (paddr_i == DSPCC_CORE_CONTROL_OFFS[ADDR_W-1:0]);
	wire        setup     = psel_i & ~penable_i;
	wire        access    = psel_i & penable_i & pready_reg;
	wire        wr_hit    = access & pwrite_i & addr_hit & pslverr_reg == 1'b0;
	wire        lo_we     = wr_hit & pstrb_i[0];
	wire        hi_we     = wr_hit & pstrb_i[1];
	wire [15:0] wdat      = pwdata_i[15:0];

	// live view of the register; depth comes straight from the loop unit
	dspcc_ctrl_t rd_view;
	assign rd_view.unused               = 3'h0;
	assign rd_view.multiply_sign_select = ctrl_reg.multiply_sign_select;
	assign rd_view.loop_early_exit      = 1'b0;
	assign rd_view.loop_nest_depth      = loop_nest_depth_i;
	assign rd_view.acc_a_clamp_en       = ctrl_reg.acc_a_clamp_en;
	assign rd_view.acc_b_clamp_en       = ctrl_reg.acc_b_clamp_en;
	assign rd_view.write_clamp_en       = ctrl_reg.write_clamp_en;
	assign rd_view.clamp_width_select   = ctrl_reg.clamp_width_select;
	assign rd_view.priority_level_msb   = ctrl_reg.priority_level_msb;
	assign rd_view.program_space_window = ctrl_reg.program_space_window;
	assign rd_view.rounding_select      = ctrl_reg.rounding_select;
	assign rd_view.int_mode_select      = ctrl_reg.int_mode_select;

	wire [31:0] rd_word = addr_hit ? {16'h0000, rd_view} : 32'h0000_0000;

	// ---------------- next register value
	wire exit_wr  = hi_we & wdat[DSPCC_EXIT_BIT];
	// hardware set beats a software clear in the same cycle
	wire msb_set  = priority_raise_i;
	wire msb_clr  = (lo_we & ~wdat[DSPCC_MSB_BIT]) | priority_drop_i;
	wire msb_next = msb_set | (ctrl_reg.priority_level_msb & ~msb_clr);

	always_comb begin
		ctrl_next = ctrl_reg;
		if (hi_we) begin
			ctrl_next.multiply_sign_select = wdat[DSPCC_US_BIT];
		end
		if (lo_we) begin
			ctrl_next.acc_a_clamp_en       = wdat[DSPCC_ACC_A_CLAMP_EN_BIT];
			ctrl_next.acc_b_clamp_en       = wdat[DSPCC_ACC_B_CLAMP_EN_BIT];
			ctrl_next.write_clamp_en       = wdat[DSPCC_SATW_BIT];
			ctrl_next.clamp_width_select   = wdat[DSPCC_WIDE_BIT];
			ctrl_next.program_space_window = wdat[DSPCC_PSW_BIT];
			ctrl_next.rounding_select      = wdat[DSPCC_RND_BIT];
			ctrl_next.int_mode_select      = wdat[DSPCC_INT_BIT];
		end
		ctrl_next.priority_level_msb = msb_next;
		ctrl_next.unused             = 3'h0;
		ctrl_next.loop_early_exit    = 1'b0;
		ctrl_next.loop_nest_depth    = 3'h0;
	end

	// a request stays pending until the running iteration closes or the loop depth reads zero;
	// a new request landing on that same edge survives to the next one
	assign exit_pend_next = exit_wr
		| (exit_pend_reg & ~loop_iter_end_i & (loop_nest_depth_i != 3'h0));

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ctrl_reg      <= dspcc_ctrl_t'(DSPCC_CORE_CONTROL_RST);
			exit_pend_reg <= 1'b0;
			term_reg      <= 1'b0;
			prio_reg      <= 4'h0;
		end else begin
			ctrl_reg      <= ctrl_next;
			exit_pend_reg <= exit_pend_next;
			term_reg      <= exit_pend_reg & loop_iter_end_i;
			prio_reg      <= {msb_next, priority_level_low_i};
		end
	end

	// ---------------- apb answer: one access cycle, data sampled in setup
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= setup ? rd_word : 32'h0000_0000;
			pready_reg  <= setup;
			pslverr_reg <= setup & ~addr_hit;
		end
	end

	// ---------------- multiplier
	wire        mul_uns   = ctrl_reg.multiply_sign_select;
	wire [16:0] mx        = {mul_uns ? 1'b0 : mul_x_i[DSPCC_OP_W-1], mul_x_i};
	wire [16:0] my        = {mul_uns ? 1'b0 : mul_y_i[DSPCC_OP_W-1], mul_y_i};
	wire [33:0] mprod     = 34'($signed(mx) * $signed(my));
	// fractional results are realigned to 1.31
	wire [31:0] mres      = ctrl_reg.int_mode_select ? mprod[31:0] : {mprod[30:0], 1'b0};

	// ---------------- accumulator saturation
	wire [DSPCC_ACC_W:0]   acc_raw [DSPCC_NUM_ACC];
	wire                   acc_en  [DSPCC_NUM_ACC];
	wire [DSPCC_ACC_W-1:0] acc_sat [DSPCC_NUM_ACC];
	assign acc_raw[0] = acc_a_i;
	assign acc_raw[1] = acc_b_i;
	assign acc_en[0]  = ctrl_reg.acc_a_clamp_en;
	assign acc_en[1]  = ctrl_reg.acc_b_clamp_en;

	genvar gi;
	generate
		for (gi = 0; gi < DSPCC_NUM_ACC; gi++) begin : g_acc
			dspcc_clamp #(
				.IN_W     (DSPCC_ACC_W + 1),
				.OUT_W    (DSPCC_ACC_W),
				.NARROW_W (DSPCC_NORM_W)
			) u_clamp (
				.value_i (acc_raw[gi]),
				.en_i    (acc_en[gi]),
				.wide_i  (ctrl_reg.clamp_width_select),
				.value_o (acc_sat[gi])
			);
			always_ff @(posedge clk_sys_i) begin
				if (!rstn_i) begin
					acc_reg[gi] <= '0;
				end else begin
					acc_reg[gi] <= acc_sat[gi];
				end
			end
		end
	endgenerate

	// ---------------- rounding and write saturation
	wire [DSPCC_ACC_W-1:0] wsrc   = acc_sat[wr_acc_sel_i];
	wire [15:0]            frac   = wsrc[DSPCC_RND_LSB-1:0];
	wire                   r_conv = (frac > DSPCC_RND_HALF)
		| ((frac == DSPCC_RND_HALF) & wsrc[DSPCC_RND_LSB]);
	wire                   r_bias = frac[DSPCC_RND_LSB-1];
	wire                   r_inc  = ctrl_reg.rounding_select ? r_bias : r_conv;
	wire [24:0]            rnd    = 25'({wsrc[DSPCC_ACC_W-1], wsrc[DSPCC_ACC_W-1:DSPCC_RND_LSB]} + 25'(r_inc));
	wire [15:0]            wsat;

	dspcc_clamp #(
		.IN_W     (25),
		.OUT_W    (DSPCC_OP_W),
		.NARROW_W (DSPCC_OP_W)
	) u_wclamp (
		.value_i (rnd),
		.en_i    (ctrl_reg.write_clamp_en),
		.wide_i  (1'b0),
		.value_o (wsat)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			product_reg <= 32'h0000_0000;
			wr_word_reg <= 16'h0000;
		end else begin
			product_reg <= mres;
			wr_word_reg <= wsat;
		end
	end

	// ---------------- outputs, all from flops
	assign prdata_o               = prdata_reg;
	assign pready_o               = pready_reg;
	assign pslverr_o              = pslverr_reg;
	assign loop_terminate_o       = term_reg;
	assign priority_level_o       = prio_reg;
	assign program_space_window_o = ctrl_reg.program_space_window;
	assign write_clamp_en_o       = ctrl_reg.write_clamp_en;
	assign mul_product_o          = product_reg;
	assign acc_a_o                = acc_reg[0];
	assign acc_b_o                = acc_reg[1];
	assign wr_word_o              = wr_word_reg;

	// ---------------- checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	AST_RSVD_ZERO: assert property (pready_o |-> prdata_o[31:DSPCC_RSVD_LSB] == 19'h00000)
		else $error("unimplemented bits read nonzero");

	AST_EXIT_READS_ZERO: assert property (pready_o |-> !prdata_o[DSPCC_EXIT_BIT])
		else $error("early exit bit read back as one");

	AST_DEPTH_READ: assert property ((setup && addr_hit) |=>
		prdata_o[DSPCC_DEPTH_MSB:DSPCC_DEPTH_LSB] == $past(loop_nest_depth_i) && pready_o)
		else $error("loop depth read mismatch");

	AST_WCLAMP_RESET: assert property ($past(!rstn_i) |-> write_clamp_en_o && !program_space_window_o)
		else $error("write clamp not set after reset");

	AST_MSB_NO_SW_SET: assert property ((!ctrl_reg.priority_level_msb && !priority_raise_i)
		|=> !ctrl_reg.priority_level_msb)
		else $error("priority msb set without hardware cause");

	AST_MSB_SET_WINS: assert property ((priority_raise_i && wr_hit) |=> priority_level_o[3])
		else $error("priority msb set lost to clear");

	AST_PRIO_JOIN: assert property (priority_level_o ==
		{ctrl_reg.priority_level_msb, $past(priority_level_low_i)})
		else $error("priority level not joined");

	AST_TERMINATE: assert property ((exit_wr && loop_nest_depth_i != 3'h0) ##1
		(loop_iter_end_i && loop_nest_depth_i != 3'h0) |=> loop_terminate_o)
		else $error("loop exit not signalled at iteration end");

	AST_TERM_CAUSE: assert property (loop_terminate_o |-> $past(exit_pend_reg) && $past(loop_iter_end_i))
		else $error("loop exit without request");

	AST_MUL_UNSIGNED: assert property ((mul_uns && ctrl_reg.int_mode_select) |=>
		mul_product_o == 32'($past(mul_x_i) * $past(mul_y_i)))
		else $error("unsigned integer product wrong");

	AST_ACC_A_WRAP: assert property (!ctrl_reg.acc_a_clamp_en |=> acc_a_o == $past(acc_a_i[DSPCC_ACC_W-1:0]))
		else $error("accumulator a saturated while disabled");

	AST_ACC_B_NORM: assert property ((ctrl_reg.acc_b_clamp_en && !ctrl_reg.clamp_width_select
		&& !acc_b_i[DSPCC_ACC_W] && acc_b_i[DSPCC_ACC_W-1:DSPCC_NORM_W-1] != '0)
		|=> acc_b_o == 40'h00_7fff_ffff)
		else $error("accumulator b not clamped to 1.31");

	AST_EXIT_ARM: assert property (exit_wr |=> exit_pend_reg)
		else $error("early exit request not held");

	AST_EXIT_IDLE_DROP: assert property ((loop_nest_depth_i == 3'h0 && !exit_wr) |=> !exit_pend_reg)
		else $error("early exit kept with no loop active");

	AST_MSB_CLEAR: assert property ((lo_we && !wdat[DSPCC_MSB_BIT] && !priority_raise_i) |=> !priority_level_o[3])
		else $error("priority msb not cleared by software");

	AST_WINDOW_WRITE: assert property (lo_we |=> program_space_window_o == $past(wdat[DSPCC_PSW_BIT]))
		else $error("program space window not written");

	AST_WCLAMP_WRITE: assert property (lo_we |=> write_clamp_en_o == $past(wdat[DSPCC_SATW_BIT]))
		else $error("write clamp enable not written");

	AST_MUL_SIGNED: assert property ((!mul_uns && ctrl_reg.int_mode_select) |=>
		mul_product_o == 32'($signed($past(mul_x_i)) * $signed($past(mul_y_i))))
		else $error("signed integer product wrong");

	AST_MUL_FRAC: assert property ((!mul_uns && !ctrl_reg.int_mode_select) |=>
		mul_product_o == (32'($signed($past(mul_x_i)) * $signed($past(mul_y_i))) << 1))
		else $error("signed fractional product wrong");

	AST_ACC_A_NORM: assert property ((ctrl_reg.acc_a_clamp_en && !ctrl_reg.clamp_width_select
		&& !acc_a_i[DSPCC_ACC_W] && acc_a_i[DSPCC_ACC_W-1:DSPCC_NORM_W-1] != '0)
		|=> acc_a_o == 40'h00_7fff_ffff)
		else $error("accumulator a not clamped to 1.31");

	AST_ACC_B_WIDE: assert property ((ctrl_reg.acc_b_clamp_en && ctrl_reg.clamp_width_select
		&& !acc_b_i[DSPCC_ACC_W] && acc_b_i[DSPCC_ACC_W-1]) |=> acc_b_o == 40'h7f_ffff_ffff)
		else $error("accumulator b not clamped to 9.31");

	AST_ACC_B_WRAP: assert property (!ctrl_reg.acc_b_clamp_en |=> acc_b_o == $past(acc_b_i[DSPCC_ACC_W-1:0]))
		else $error("accumulator b saturated while disabled");

	AST_WSAT_POS: assert property ((ctrl_reg.write_clamp_en && !rnd[24] && rnd[23:DSPCC_OP_W-1] != '0)
		|=> wr_word_o == 16'h7fff)
		else $error("write word not saturated");

	AST_ERR_WITH_ACK: assert property (pslverr_o |-> pready_o)
		else $error("bus error without ready");

	AST_ACK_SINGLE: assert property (pready_o |=> !pready_o)
		else $error("ready held beyond one cycle");

endmodule

// >>> tb/test_dsp_core_control_register.sv
module test_dsp_core_control_register;
	timeunit 1ns;
	timeprecision 1ps;
	import dspcc_pkg::*;

	logic        clk   = 1'b0;
	logic        rstn  = 1'b0;
	logic        psel  = 1'b0;
	logic        pen   = 1'b0;
	logic        pwr   = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwd   = 32'h0;
	logic [3:0]  pstrb = 4'h3;
	logic [2:0]  depth = 3'h0;
	logic        iend  = 1'b0;
	logic [2:0]  plow  = 3'h0;
	logic        raise = 1'b0;
	logic        drop  = 1'b0;
	logic [15:0] mx    = 16'h0;
	logic [15:0] my    = 16'h0;
	logic [40:0] acc_a = 41'h0;
	logic [40:0] acc_b = 41'h0;
	logic        sel   = 1'b0;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic        term;
	logic [3:0]  plev;
	logic        psw;
	logic        wce;
	logic [31:0] prod;
	logic [39:0] ao;
	logic [39:0] bo;
	logic [15:0] wword;
	int          fail_count = 0;
	int          check_count = 0;

	dspcc_core_control dut_u (.clk_sys_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwd), .pstrb_i(pstrb), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.loop_nest_depth_i(depth), .loop_iter_end_i(iend), .loop_terminate_o(term),
		.priority_level_low_i(plow), .priority_raise_i(raise), .priority_drop_i(drop), .priority_level_o(plev),
		.program_space_window_o(psw), .write_clamp_en_o(wce), .mul_x_i(mx), .mul_y_i(my), .mul_product_o(prod),
		.acc_a_i(acc_a), .acc_b_i(acc_b), .acc_a_o(ao), .acc_b_o(bo), .wr_acc_sel_i(sel), .wr_word_o(wword));

	initial begin
		forever #10 clk = ~clk;
	end

	task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		check_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwd <= {16'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		// no wait limit here: a hang is ended by the watchdog
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, a, 16'h0, rd, er);
		chk("read data", {8'h0, e}, {8'h0, rd});
		chk("read error", {39'h0, ee}, {39'h0, er});
	endtask

	task wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, a, d, rd, er);
		chk("write error", {39'h0, a != DSPCC_CORE_CONTROL_OFFS}, {39'h0, er});
	endtask

	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task t_reset;
		rdchk(DSPCC_CORE_CONTROL_OFFS, 32'h0020, 1'b0);
		chk("write clamp", 40'h1, {39'h0, wce});
		$display("test reset done");
	endtask

	task t_fields;
		@(posedge clk) depth <= 3'h7;
		wr(DSPCC_CORE_CONTROL_OFFS, 16'hffff);
		#1 chk("window", 40'h1, {39'h0, psw});
		rdchk(DSPCC_CORE_CONTROL_OFFS, 32'h17f7, 1'b0);
		wr(DSPCC_CORE_CONTROL_OFFS, 16'h0000);
		#1 chk("window", 40'h0, {39'h0, psw});
		chk("write clamp", 40'h0, {39'h0, wce});
		rdchk(12'h004, 32'h0, 1'b1);
		wr(12'h004, 16'h0004);
		rdchk(DSPCC_CORE_CONTROL_OFFS, 32'h0700, 1'b0);
		// low lane only: upper byte, early exit included, must stay untouched
		@(posedge clk) pstrb <= 4'h1;
		wr(DSPCC_CORE_CONTROL_OFFS, 16'hffff);
		rdchk(DSPCC_CORE_CONTROL_OFFS, 32'h07f7, 1'b0);
		@(posedge clk) pstrb <= 4'h3;
		$display("test fields done");
	endtask

	task t_exit;
		// depth zero drops any exit left armed earlier
		@(posedge clk) depth <= 3'h0;
		repeat (2) @(posedge clk);
		depth <= 3'h2;
		wr(DSPCC_CORE_CONTROL_OFFS, 16'h0800);
		iend <= 1'b1;
		#1 chk("terminate early", 40'h0, {39'h0, term});
		@(posedge clk) iend <= 1'b0;
		#1 chk("terminate", 40'h1, {39'h0, term});
		@(posedge clk) #1 chk("terminate end", 40'h0, {39'h0, term});
		wr(DSPCC_CORE_CONTROL_OFFS, 16'h0000);
		iend <= 1'b1;
		@(posedge clk) iend <= 1'b0;
		#1 chk("terminate zero", 40'h0, {39'h0, term});
		$display("test exit done");
	endtask

	task t_prio;
		@(posedge clk) plow <= 3'h6;
		raise <= 1'b1;
		@(posedge clk) raise <= 1'b0;
		#1 chk("priority", 40'he, {36'h0, plev});
		rdchk(DSPCC_CORE_CONTROL_OFFS, 32'h0208, 1'b0);
		wr(DSPCC_CORE_CONTROL_OFFS, 16'h0008);
		#1 chk("priority set write", 40'he, {36'h0, plev});
		wr(DSPCC_CORE_CONTROL_OFFS, 16'h0000);
		#1 chk("priority clear", 40'h6, {36'h0, plev});
		@(posedge clk) raise <= 1'b1;
		@(posedge clk) raise <= 1'b0;
		drop <= 1'b1;
		@(posedge clk) drop <= 1'b0;
		#1 chk("priority drop", 40'h6, {36'h0, plev});
		// hardware set and software clear land on the same edge
		@(posedge clk) raise <= 1'b1;
		wr(DSPCC_CORE_CONTROL_OFFS, 16'h0000);
		raise <= 1'b0;
		#1 chk("priority set wins", 40'he, {36'h0, plev});
		$display("test priority done");
	endtask

	task t_mul;
		logic [15:0] mc[4] = '{16'h0000, 16'h0001, 16'h1000, 16'h1001};
		logic [31:0] me[4] = '{32'hfffffffc, 32'hfffffffe, 32'h0003fffc, 32'h0001fffe};
		@(posedge clk) mx <= 16'hffff;
		my <= 16'h0002;
		for (int i = 0; i < 4; i++) begin
			wr(DSPCC_CORE_CONTROL_OFFS, mc[i]);
			settle;
			chk("product", {8'h0, me[i]}, {8'h0, prod});
		end
		$display("test multiply done");
	endtask

	task t_acc;
		logic [15:0] ac[5] = '{16'h00c0, 16'h00d0, 16'h0010, 16'h0080, 16'h0040};
		logic [39:0] ea[5] = '{40'h007fffffff, 40'h0100000000, 40'h0100000000, 40'h007fffffff, 40'h0100000000};
		logic [39:0] eb[5] = '{40'h007fffffff, 40'h7fffffffff, 40'h8000000000, 40'h8000000000, 40'h007fffffff};
		@(posedge clk) acc_a <= 41'h00100000000;
		acc_b <= 41'h08000000000;
		for (int i = 0; i < 5; i++) begin
			wr(DSPCC_CORE_CONTROL_OFFS, ac[i]);
			settle;
			chk("acc a", ea[i], ao);
			chk("acc b", eb[i], bo);
		end
		$display("test clamp done");
	endtask

	task t_round;
		logic [15:0] rc[4] = '{16'h0020, 16'h0022, 16'h0020, 16'h0000};
		logic        rs[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
		logic [15:0] re[4] = '{16'h0002, 16'h0003, 16'h7fff, 16'h0000};
		@(posedge clk) acc_a <= 41'h00000028000;
		acc_b <= 41'h00100000000;
		for (int i = 0; i < 4; i++) begin
			wr(DSPCC_CORE_CONTROL_OFFS, rc[i]);
			sel <= rs[i];
			settle;
			chk("write word", {24'h0, re[i]}, {24'h0, wword});
		end
		$display("test rounding done");
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_fields;
		t_exit;
		t_prio;
		t_mul;
		t_acc;
		t_round;
		test_done;
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		test_done;
	end
endmodule
